// ### hw/lvr_pkg.sv
package lvr_pkg;
    // reset source status layout
    localparam int SRS_W        = 8;
    localparam int SRS_POR_BIT  = 7;
    localparam int SRS_PIN_BIT  = 6;
    localparam int SRS_WDG_BIT  = 5;
    localparam int SRS_ILOP_BIT = 4;
    localparam int SRS_ILAD_BIT = 3;
    localparam int SRS_PWU_BIT  = 2;
    localparam int SRS_LVD_BIT  = 1;
    localparam logic [7:0] SRS_RESET_VAL = 8'h82;
    // vectors
    localparam int VEC_W = 4;
    localparam logic [3:0] VEC_RESET    = 4'h0;
    localparam logic [3:0] VEC_SWI      = 4'h1;
    localparam logic [3:0] VEC_LVD      = 4'h3;
    localparam logic [3:0] VEC_WAKE     = 4'h4;
    localparam logic [3:0] VEC_TCH0     = 4'h5;
    localparam logic [3:0] VEC_TCH1     = 4'h6;
    localparam logic [3:0] VEC_TOVF     = 4'h7;
    localparam logic [3:0] VEC_KEY      = 4'hf;
    // bus divider
    localparam logic [1:0] DIV_RESET_VAL = 2'h0;
    localparam int KEY_W = 4;
    localparam int WAKE_W = 6;
    typedef enum logic [2:0] {
        LVR_RUN   = 3'b001,
        LVR_HOLD  = 3'b010,
        LVR_STOP  = 3'b100
    } lvr_state_type;
endpackage

// ### hw/lvr_div_if.sv
`timescale 1ns/100ps
interface lvr_div_if;
    logic [1:0] select;
    logic       fast_osc_en;
    logic       bus_en;
    modport ctrl (output select, input fast_osc_en, input bus_en);
    modport div  (input select, output fast_osc_en, output bus_en);
endinterface

// ### hw/lvr_clk_div.sv
`timescale 1ns/100ps
module lvr_clk_div (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // divider link
    lvr_div_if.div   dv
);
    import lvr_pkg::*;

    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [3:0] osc_last;

    ////////////////////////////////////////////////////////////////
    // 8 mhz oscillator from 100 mhz is not integral; model divided
    // oscillator as enables at 1/1, 1/2, 1/4 or 1/8 of core_clk by select
    always_comb begin
        next_cnt = cnt + 4'h1;
        case (dv.select)
            2'h0:    osc_last = 4'h0;
            2'h1:    osc_last = 4'h1;
            2'h2:    osc_last = 4'h3;
            default: osc_last = 4'h7;
        endcase
        if (cnt >= osc_last) begin
            next_cnt = 4'h0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt <= 4'h0;
        end else begin
            cnt <= next_cnt;
        end
    end

    logic osc_tick;
    logic bus_ph;
    logic next_bus_ph;
    assign osc_tick = (cnt >= osc_last);
    always_comb begin
        next_bus_ph = bus_ph;
        if (osc_tick) begin
            next_bus_ph = ~bus_ph;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            bus_ph <= 1'b0;
        end else begin
            bus_ph <= next_bus_ph;
        end
    end
    // bus rate is half the oscillator rate
    assign dv.fast_osc_en = osc_tick;
    assign dv.bus_en      = osc_tick & bus_ph;
endmodule

// ### hw/lvr_sys_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// [RULE_01] detector active only while enabled; level bit picks high or low trip
// [RULE_02] stop entry disables detector unless stop-enable is set
// [RULE_03] stop-enable with enable set blocks the deepest stop
// [RULE_04] power-on or supply below power-on level asserts reset
// [RULE_05] after power-on, hold reset until supply above selected level
// [RULE_06] power-on sets power-on and low-voltage status flags
// [RULE_07] reset-enabled low supply resets and holds until recovery
// [RULE_08] low-voltage reset also sets the low-voltage status flag
// [RULE_09] enabled detector with irq enable, no reset enable, sets flag and irq
// [RULE_10] warning flag sets below warning level, uncleared while below
// [RULE_11] writing one to warning acknowledge clears warning flag
// [RULE_12] warning never raises an interrupt
// [RULE_13] two warning levels chosen by warning select bit
// [RULE_14] divider select: 00 8/4, 01 4/2, 10 2/1, 11 1/0.5 mhz
// [RULE_15] any reset clears divider select to fastest rate
// [RULE_16] port a pins 0..3 act as key wake interrupts
// [RULE_17] low-voltage irq vector 3 outranks vectors 4 to 7
// [RULE_18] wake timer interrupts on vector 4 when interval nonzero
// [RULE_19] software interrupt always requests vector 1
// [RULE_20] periodic reset forces vector 0 and sets its flag
// [RULE_21] enabled temperature restart forces reset on vector 0
// [RULE_22] illegal opcode/address, watchdog, low-voltage reset use vector 0
// [RULE_23] with reset enable, detection gives reset, no interrupt
// [RULE_24] any vector fetch wakes from any stop mode
module lvr_sys_ctrl (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    // analog comparators
    input  wire logic                 supply_below_por,
    input  wire logic                 supply_below_vdet_high,
    input  wire logic                 supply_below_vdet_low,
    input  wire logic                 supply_below_warn_high,
    input  wire logic                 supply_below_warn_low,
    input  wire logic                 temp_crossed,
    // control bits
    input  wire logic                 vdet_enable,
    input  wire logic                 vdet_level_select,
    input  wire logic                 vdet_stop_enable,
    input  wire logic                 vdet_reset_enable,
    input  wire logic                 vdet_irq_enable,
    input  wire logic                 vdet_ack,
    input  wire logic                 vwarn_level_select,
    input  wire logic                 vwarn_ack,
    input  wire logic [1:0]           bus_divider_select_wr,
    input  wire logic                 bus_divider_write,
    input  wire logic                 temp_restart_enable,
    input  wire logic                 watchdog_enable,
    // stop requests
    input  wire logic                 stop_request,
    input  wire logic                 deepest_stop_request,
    // other sources
    input  wire logic [lvr_pkg::KEY_W-1:0] port_a_pin,
    input  wire logic [lvr_pkg::KEY_W-1:0] key_wake_enable,
    input  wire logic                 wake_interval_flag,
    input  wire logic [lvr_pkg::WAKE_W-1:0] wake_interval_field,
    input  wire logic                 periodic_reset_event,
    input  wire logic                 watchdog_timeout,
    input  wire logic                 illegal_opcode,
    input  wire logic                 illegal_address,
    input  wire logic                 software_interrupt,
    input  wire logic                 timer_overflow_req,
    input  wire logic                 timer_channel1_req,
    input  wire logic                 timer_channel0_req,
    input  wire logic                 irq_mask,
    // status and outputs
    output logic                      chip_reset,
    output logic [lvr_pkg::SRS_W-1:0] reset_source_status,
    output logic                      vdet_flag,
    output logic                      vwarn_flag,
    output logic                      periodic_reset_flag,
    output logic                      vdet_active,
    output logic                      in_stop,
    output logic                      in_deepest_stop,
    output logic                      irq_pending,
    output logic [lvr_pkg::VEC_W-1:0] vector_number,
    output logic [1:0]                bus_divider_select,
    output logic                      fast_osc_en,
    output logic                      bus_en
);
    import lvr_pkg::*;

    ////////////////////////////////////////////////////////////////
    // detector
    lvr_state_type state;
    lvr_state_type next_state;
    logic below_vdet;
    logic below_warn;
    logic det_on;
    logic soft_reset_src;
    logic lvd_reset;
    logic key_hit;
    logic wake_req;
    logic vec_fetch;

    assign below_vdet = vdet_level_select ? supply_below_vdet_high
                                          : supply_below_vdet_low; // RULE_01
    assign below_warn = vwarn_level_select ? supply_below_warn_high
                                           : supply_below_warn_low; // RULE_13
    // stop turns the detector off unless stop-enable is set
    assign det_on = vdet_enable &
                    (state != LVR_STOP | vdet_stop_enable); // RULE_01 RULE_02
    assign lvd_reset = det_on & vdet_reset_enable & below_vdet; // RULE_07
    assign key_hit = |(port_a_pin & key_wake_enable); // RULE_16
    assign wake_req = wake_interval_flag & (|wake_interval_field); // RULE_18
    assign soft_reset_src = periodic_reset_event // RULE_20
                          | (temp_restart_enable & temp_crossed) // RULE_21
                          | illegal_opcode | illegal_address // RULE_22
                          | (watchdog_enable & watchdog_timeout);

    ////////////////////////////////////////////////////////////////
    // reset and stop sequencing
    logic stop_deep;
    logic next_stop_deep;

    always_comb begin
        next_state     = state;
        next_stop_deep = stop_deep;
        case (state)
            LVR_RUN: begin
                if (supply_below_por | lvd_reset) begin
                    next_state = LVR_HOLD; // RULE_04 RULE_07
                end else if (stop_request & ~soft_reset_src) begin
                    next_state     = LVR_STOP;
                    // deepest stop refused while detector kept in stop
                    next_stop_deep = deepest_stop_request &
                        ~(vdet_stop_enable & vdet_enable); // RULE_03
                end
            end

            LVR_HOLD: begin
                // leave only once supply is above selected level
                if (~supply_below_por & ~below_vdet) begin
                    next_state = LVR_RUN; // RULE_05 RULE_07
                end
            end

            LVR_STOP: begin
                if (supply_below_por | lvd_reset) begin
                    next_state = LVR_HOLD;
                end else if (vec_fetch | soft_reset_src) begin
                    next_state     = LVR_RUN; // RULE_24
                    next_stop_deep = 1'b0;
                end
            end

            default: next_state = LVR_HOLD;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state     <= LVR_HOLD;
            stop_deep <= 1'b0;
        end else begin
            state     <= next_state;
            stop_deep <= next_stop_deep;
        end
    end

    // deepest-stop exit is a full reset, as is temperature restart
    logic do_reset;
    assign do_reset = supply_below_por | lvd_reset | soft_reset_src |
                      (state == LVR_STOP & stop_deep & vec_fetch);

    ////////////////////////////////////////////////////////////////
    // flags and status
    logic [7:0] next_srs;
    logic       next_vdet_flag;
    logic       next_vwarn_flag;
    logic       next_prf;
    logic [1:0] next_div;

    always_comb begin
        next_srs        = reset_source_status;
        next_vdet_flag  = vdet_flag;
        next_vwarn_flag = vwarn_flag;
        next_prf        = periodic_reset_flag;
        next_div        = bus_divider_select;
        if (bus_divider_write) begin
            next_div = bus_divider_select_wr; // RULE_14
        end

        if (vdet_ack) begin
            next_vdet_flag = 1'b0;
        end

        // interrupt mode only when reset enable is clear
        if (det_on & vdet_irq_enable & ~vdet_reset_enable & below_vdet) begin
            next_vdet_flag = 1'b1; // RULE_09 RULE_23
        end

        if (vwarn_ack) begin
            next_vwarn_flag = 1'b0; // RULE_11
        end

        if (below_warn) begin
            next_vwarn_flag = 1'b1; // RULE_10
        end

        if (do_reset) begin
            next_div = DIV_RESET_VAL; // RULE_15
            next_vdet_flag = 1'b0;
            next_srs = 8'h00;
            if (supply_below_por | lvd_reset) begin
                next_srs = SRS_RESET_VAL; // RULE_06 RULE_08
            end else begin
                next_srs[SRS_WDG_BIT]  = watchdog_enable & watchdog_timeout;
                next_srs[SRS_ILOP_BIT] = illegal_opcode;
                next_srs[SRS_ILAD_BIT] = illegal_address;
                next_srs[SRS_PWU_BIT]  = periodic_reset_event;
            end
            if (periodic_reset_event) begin
                next_prf = 1'b1; // RULE_20
            end
        end

        // a sequencer hold is a reset even with no cause left
        if (state == LVR_HOLD) begin
            next_div       = DIV_RESET_VAL; // RULE_15
            next_vdet_flag = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reset_source_status <= SRS_RESET_VAL;
            vdet_flag           <= 1'b0;
            vwarn_flag          <= 1'b0;
            periodic_reset_flag <= 1'b0;
            bus_divider_select  <= DIV_RESET_VAL;
        end else begin
            reset_source_status <= next_srs;
            vdet_flag           <= next_vdet_flag;
            vwarn_flag          <= next_vwarn_flag;
            periodic_reset_flag <= next_prf;
            bus_divider_select  <= next_div;
        end
    end

    ////////////////////////////////////////////////////////////////
    // vector priority; warning has no vector at all
    logic [3:0] vec;
    logic       any_irq;

    always_comb begin
        any_irq = 1'b1;
        if (software_interrupt) begin
            vec = VEC_SWI; // RULE_19
        end else if (vdet_flag & vdet_irq_enable) begin
            vec = VEC_LVD; // RULE_17
        end else if (wake_req) begin
            vec = VEC_WAKE; // RULE_18
        end else if (timer_channel0_req) begin
            vec = VEC_TCH0;
        end else if (timer_channel1_req) begin
            vec = VEC_TCH1;
        end else if (timer_overflow_req) begin
            vec = VEC_TOVF;
        end else if (key_hit) begin
            vec = VEC_KEY; // RULE_16
        end else begin
            vec     = VEC_RESET;
            any_irq = 1'b0;
        end
    end
    // software interrupt ignores the mask
    assign vec_fetch = any_irq & (~irq_mask | software_interrupt); // RULE_12

    // registered, so the vector lags its cause by one cycle
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            vector_number <= VEC_RESET;
        end else if (do_reset) begin
            vector_number <= VEC_RESET; // RULE_22
        end else begin
            vector_number <= vec;
        end
    end

    // comb, so a cause stops the core in its own cycle
    assign irq_pending     = vec_fetch;
    assign chip_reset      = (state == LVR_HOLD) | do_reset;
    assign vdet_active     = det_on;
    assign in_stop         = (state == LVR_STOP);
    assign in_deepest_stop = (state == LVR_STOP) & stop_deep;

    ////////////////////////////////////////////////////////////////
    // clock divider
    lvr_div_if dvi ();
    assign dvi.select = bus_divider_select;

    lvr_clk_div u_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .dv       (dvi.div)
    );
    assign fast_osc_en = dvi.fast_osc_en;
    assign bus_en      = dvi.bus_en;
endmodule

// ### bench/lvr_core_model.sv
`timescale 1ns/100ps
module lvr_core_model (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // service request and detector flag
    input  wire logic serve,
    input  wire logic vdet_flag,
    // core side controls
    output logic      vdet_ack,
    output logic      irq_mask
);
    logic [1:0] wait_cnt;
    logic [1:0] next_wait_cnt;
    logic       next_vdet_ack;
    // mask held while the handler runs, as the cpu sets its i bit
    assign irq_mask = serve && vdet_flag;
    ////////////////////////////////////////////////////////////////
    // slow firmware: ack lands three cycles into the handler
    always_comb begin
        next_wait_cnt = 2'h0;
        next_vdet_ack = 1'b0;
        if (serve && vdet_flag) begin
            next_wait_cnt = wait_cnt + 2'h1;
            next_vdet_ack = (wait_cnt == 2'h2);
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wait_cnt <= 2'h0;
            vdet_ack <= 1'b0;
        end else begin
            wait_cnt <= next_wait_cnt;
            vdet_ack <= next_vdet_ack;
        end
    end
endmodule

// ### bench/lvr_sys_ctrl_sva.sv
`timescale 1ns/100ps
module lvr_sys_ctrl_sva (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       supply_below_por,
    input wire logic       supply_below_vdet_high,
    input wire logic       supply_below_vdet_low,
    input wire logic       supply_below_warn_high,
    input wire logic       supply_below_warn_low,
    input wire logic       vdet_enable,
    input wire logic       vdet_level_select,
    input wire logic       vdet_stop_enable,
    input wire logic       vdet_reset_enable,
    input wire logic       vdet_irq_enable,
    input wire logic       vwarn_level_select,
    input wire logic       vwarn_ack,
    input wire logic       software_interrupt,
    input wire logic       irq_mask,
    input wire logic       chip_reset,
    input wire logic       vdet_flag,
    input wire logic       vwarn_flag,
    input wire logic       vdet_active,
    input wire logic       in_stop,
    input wire logic       in_deepest_stop,
    input wire logic [3:0] vector_number,
    input wire logic [1:0] bus_divider_select
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire logic det_low = vdet_level_select ? supply_below_vdet_high
                                           : supply_below_vdet_low;
    wire logic warn_low = vwarn_level_select ? supply_below_warn_high
                                             : supply_below_warn_low;
    ////////////////////////////////////////////////////////////////
    chk_det_irq_set: assert property (vdet_enable && vdet_irq_enable &&
        !vdet_reset_enable && det_low && !chip_reset && !in_stop
        |=> vdet_flag) else $error("detector flag not set");
    chk_det_reset: assert property (vdet_active && vdet_reset_enable &&
        det_low |-> chip_reset) else $error("low supply gave no reset");
    chk_por_reset: assert property (supply_below_por |-> chip_reset)
        else $error("power-on level gave no reset");
    chk_warn_held: assert property (warn_low && !chip_reset
        |=> vwarn_flag) else $error("warning flag not held");
    chk_warn_ack: assert property (vwarn_ack && !warn_low &&
        !chip_reset |=> !vwarn_flag) else $error("warning ack ignored");
    chk_div_cleared: assert property (chip_reset
        |=> bus_divider_select == 2'h0) else $error("divider kept");
    chk_deep_refused: assert property (vdet_enable && vdet_stop_enable
        |-> !in_deepest_stop) else $error("deepest stop entered");
    chk_stop_off: assert property (in_stop && !vdet_stop_enable
        |-> !vdet_active) else $error("detector on in stop");
    chk_det_gated: assert property (!vdet_enable |-> !vdet_active)
        else $error("detector on while disabled");
    chk_swi_vector: assert property (software_interrupt && !irq_mask
        && !chip_reset |-> ##[1:2] vector_number == 4'h1)
        else $error("software interrupt vector wrong");
    cov_det_irq: cover property (vdet_flag && vector_number == 4'h3);
    cov_refuse: cover property (in_stop && vdet_stop_enable);
    cov_warn: cover property (vwarn_flag && vwarn_ack);
endmodule
bind lvr_sys_ctrl lvr_sys_ctrl_sva lvr_sys_ctrl_sva_inst (.*);

// ### bench/test_lvr_sys_ctrl.sv
`timescale 1ns/100ps
module test_lvr_sys_ctrl;
    import lvr_pkg::*;
    logic core_clk, rst_n, serve, vdet_ack, irq_mask, temp_crossed;
    logic supply_below_por, supply_below_vdet_high, supply_below_vdet_low;
    logic supply_below_warn_high, supply_below_warn_low, vdet_enable;
    logic vdet_level_select, vdet_stop_enable, vdet_reset_enable;
    logic vdet_irq_enable, vwarn_level_select, vwarn_ack, bus_divider_write;
    logic temp_restart_enable, watchdog_enable, stop_request;
    logic deepest_stop_request, wake_interval_flag, periodic_reset_event;
    logic watchdog_timeout, illegal_opcode, illegal_address;
    logic software_interrupt, timer_overflow_req, timer_channel1_req;
    logic timer_channel0_req, chip_reset, vdet_flag, vwarn_flag;
    logic periodic_reset_flag, vdet_active, in_stop, in_deepest_stop;
    logic irq_pending, fast_osc_en, bus_en;
    logic [1:0] bus_divider_select_wr, bus_divider_select;
    logic [3:0] port_a_pin, key_wake_enable, vector_number;
    logic [5:0] wake_interval_field;
    logic [7:0] reset_source_status;
    int         errors = 0;
    int         samples_checked = 0;
    lvr_sys_ctrl   lvr_sys_ctrl_inst (.*);
    lvr_core_model lvr_core_model_inst (.*);
    always #5 core_clk = ~core_clk;
    ////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input int e);
        samples_checked++;
        if (seen !== e[7:0]) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr_div(input logic [1:0] v);
        bus_divider_select_wr = v;
        bus_divider_write = 1'b1;
        cyc(1);
        bus_divider_write = 1'b0;
        cyc(1);
    endtask
    // lowest vector number wins among pending sources
    function automatic int vec_exp(input int m);
        int t[6] = '{1, 3, 4, 5, 6, 7};
        for (int i = 0; i < 6; i++) if (m[i]) return t[i];
        return 0;
    endfunction
    initial begin
        #100000;
        errors++;
        test_done;
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        int lsel, wsel, n, m;
        int lst[6] = '{1, 4, 8, 16, 32, 61};
        void'($urandom(57727));
        {core_clk, rst_n, serve, temp_crossed, supply_below_por} = '0;
        {supply_below_vdet_high, supply_below_vdet_low, vdet_enable} = '0;
        {supply_below_warn_high, supply_below_warn_low} = '0;
        {vdet_level_select, vdet_stop_enable, vdet_reset_enable} = '0;
        {vdet_irq_enable, vwarn_level_select, vwarn_ack} = '0;
        {bus_divider_write, bus_divider_select_wr, stop_request} = '0;
        {temp_restart_enable, watchdog_enable, deepest_stop_request} = '0;
        {wake_interval_flag, periodic_reset_event, watchdog_timeout} = '0;
        {illegal_opcode, illegal_address, software_interrupt} = '0;
        {timer_overflow_req, timer_channel1_req, timer_channel0_req} = '0;
        port_a_pin = 4'($urandom);
        key_wake_enable = 4'h0;
        wake_interval_field = 6'h01 + 6'($urandom % 63);
        cyc(2);
        rst_n = 1'b1;
        {supply_below_por, supply_below_vdet_high} = 2'h3;
        supply_below_vdet_low = 1'b1;
        cyc(1);
        chk("por_rst", chip_reset, 1);
        supply_below_por = 1'b0;
        cyc(2);
        chk("por_hold", chip_reset, 1);
        {supply_below_vdet_high, supply_below_vdet_low} = 2'h0;
        cyc(2);
        chk("por_run", chip_reset, 0);
        chk("por_srs", reset_source_status, 'h82);
        // detector interrupt, wake timer already pending below it
        lsel = $urandom % 2;
        vdet_level_select = lsel[0];
        {vdet_enable, vdet_irq_enable, wake_interval_flag} = 3'h7;
        if (lsel) supply_below_vdet_low = 1'b1;
        else supply_below_vdet_high = 1'b1;
        cyc(2);
        chk("det_unsel", vdet_flag, 0);
        {supply_below_vdet_high, supply_below_vdet_low} = 2'h3;
        cyc(1);
        chk("det_flag", vdet_flag, 1);
        chk("det_irq", irq_pending, 1);
        cyc(1);
        chk("det_vec", vector_number, vec_exp(6));
        {supply_below_vdet_high, supply_below_vdet_low} = 2'h0;
        serve = 1'b1;
        cyc(6);
        chk("det_ack", vdet_flag, 0);
        serve = 1'b0;
        foreach (lst[i]) begin
            m = lst[i];
            {timer_overflow_req, timer_channel1_req, timer_channel0_req,
             wake_interval_flag, software_interrupt} = {m[5:2], m[0]};
            cyc(3);
            chk("vec", vector_number, vec_exp(m));
            {timer_overflow_req, timer_channel1_req} = 2'h0;
            {timer_channel0_req, wake_interval_flag} = 2'h0;
            software_interrupt = 1'b0;
            cyc(2);
        end
        key_wake_enable = 4'(1 << ($urandom % 4));
        port_a_pin = key_wake_enable;
        cyc(2);
        chk("key_vec", vector_number, 15);
        port_a_pin = ~key_wake_enable;
        cyc(2);
        chk("key_off", irq_pending, 0);
        {wake_interval_field, wake_interval_flag} = 7'h01;
        cyc(2);
        chk("wake_off", irq_pending, 0);
        wsel = $urandom % 2;
        vwarn_level_select = wsel[0];
        if (wsel) supply_below_warn_low = 1'b1;
        else supply_below_warn_high = 1'b1;
        cyc(2);
        chk("warn_unsel", vwarn_flag, 0);
        {supply_below_warn_high, supply_below_warn_low} = 2'h3;
        cyc(2);
        chk("warn_set", vwarn_flag, 1);
        chk("warn_irq", irq_pending, 0);
        for (int k = 0; k < 2; k++) begin
            vwarn_ack = 1'b1;
            cyc(1);
            vwarn_ack = 1'b0;
            cyc(1);
            chk("warn_ack", vwarn_flag, 1 - k);
            {supply_below_warn_high, supply_below_warn_low} = 2'h0;
        end
        // detector in reset mode
        vdet_reset_enable = 1'b1;
        {supply_below_vdet_high, supply_below_vdet_low} = 2'h3;
        cyc(1);
        chk("lvr_rst", chip_reset, 1);
        chk("lvr_irq", irq_pending, 0);
        cyc(2);
        chk("lvr_hold", chip_reset, 1);
        chk("lvr_flag", vdet_flag, 0);
        {supply_below_vdet_high, supply_below_vdet_low} = 2'h0;
        cyc(3);
        chk("lvr_run", chip_reset, 0);
        chk("lvr_srs", reset_source_status, 'h82);
        vdet_reset_enable = 1'b0;
        for (int s = 0; s < 4; s++) begin
            wr_div(2'(s));
            chk("div_sel", bus_divider_select, s);
            n = 0;
            m = 0;
            repeat (16) begin
                cyc(1);
                n += int'(fast_osc_en);
                m += int'(bus_en);
            end
            chk("osc_rate", 8'(n), 16 >> s);
            chk("bus_rate", 8'(m), 8 >> s);
        end
        {temp_restart_enable, watchdog_enable} = 2'h3;
        for (int i = 0; i < 5; i++) begin
            wr_div(2'h3);
            {temp_crossed, watchdog_timeout, illegal_opcode, illegal_address,
             periodic_reset_event} = 5'(1 << i);
            #1;
            chk("rst_now", chip_reset, 1);
            cyc(1);
            {temp_crossed, watchdog_timeout, illegal_opcode} = 3'h0;
            {illegal_address, periodic_reset_event} = 2'h0;
            chk("rst_div", bus_divider_select, 0);
            if (i < 4) chk("rst_srs", reset_source_status, 4 << i);
            if (i == 0) chk("prf", periodic_reset_flag, 1);
            cyc(3);
        end
        {vdet_stop_enable, deepest_stop_request, stop_request} = 3'h7;
        cyc(1);
        {deepest_stop_request, stop_request} = 2'h0;
        cyc(1);
        chk("stop_in", in_stop, 1);
        chk("stop_deep", in_deepest_stop, 0);
        chk("stop_det", vdet_active, 1);
        software_interrupt = 1'b1;
        cyc(3);
        chk("stop_wake", in_stop, 0);
        {software_interrupt, vdet_stop_enable, stop_request} = 3'h1;
        cyc(1);
        stop_request = 1'b0;
        cyc(1);
        chk("stop_off", vdet_active, 0);
        software_interrupt = 1'b1;
        cyc(1);
        {software_interrupt, vdet_enable} = 2'h0;
        {deepest_stop_request, stop_request} = 2'h3;
        cyc(1);
        {deepest_stop_request, stop_request} = 2'h0;
        chk("deep_in", in_deepest_stop, 1);
        software_interrupt = 1'b1;
        #1;
        chk("deep_exit", chip_reset, 1);
        test_done;
    end
endmodule
